// ===== usbd_defs.svh
// constants of the full-speed device port core
`ifndef USBD_DEFS_SVH
`define USBD_DEFS_SVH
`define USBD_CLK_HZ 100000000
`define USBD_BIT_HZ 12000000
`define USBD_BIT_DIV (`USBD_CLK_HZ / `USBD_BIT_HZ)
`define USBD_SUSP_MS 3
`define USBD_WAKE_MS 10
`define USBD_SUSP_CYC (`USBD_SUSP_MS * (`USBD_CLK_HZ / 1000))
`define USBD_WAKE_CYC (`USBD_WAKE_MS * (`USBD_CLK_HZ / 1000))
`define USBD_EP_NUM 6
`define USBD_EP0_MAX 9'h008
`define USBD_EP13_MAX 9'h040
`define USBD_EP45_MAX 9'h100
`define USBD_FIFO_DEPTH 16
`define USBD_CNT_W 24
`define USBD_FILL_W 9
`define USBD_DIV_W 4
`endif

// ===== usbd_pkg.sv
// types of the full-speed device port core
`include "usbd_defs.svh"
package usbd_pkg;
  typedef enum logic [2:0] {
    USBD_ACTIVE = 3'b001,
    USBD_SUSPEND = 3'b010,
    USBD_WAKE = 3'b100
  } usbd_link_t;

  typedef logic [`USBD_EP_NUM-1:0] usbd_epmask_t;

  typedef struct packed {
    usbd_link_t state;
    logic [2:0] sync_dp;
    logic [2:0] sync_dm;
    logic [2:0] sync_wk;
    logic line_j;
    logic line_k;
    logic wk_lvl;
    logic [`USBD_CNT_W-1:0] cnt;
    logic [`USBD_DIV_W-1:0] div;
    logic bit_en;
    usbd_epmask_t cpu_bank;
    usbd_epmask_t sie_bank;
    logic [2*`USBD_EP_NUM-1:0] owned;
    logic [`USBD_EP_NUM*`USBD_FILL_W-1:0] fill;
    usbd_epmask_t bank_free;
    usbd_epmask_t sie_ready;
    logic cfg_error;
    logic susp_flag;
    logic resume_flag;
    logic irq;
    logic dp_out;
    logic dm_out;
    logic dp_oe;
    logic dm_oe;
  } usbd_state_t;
endpackage : usbd_pkg

// ===== usbd_fifo.sv
// byte fifo between the processor port and the endpoint banks
`timescale 1ns/1ps
module usbd_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_valid,
  input wire logic [WIDTH-1:0] s_data,
  output logic s_ready,
  output logic m_valid,
  output logic [WIDTH-1:0] m_data,
  input wire logic m_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic full;
    logic empty;
  } usbd_fifo_st_t;

  usbd_fifo_st_t st;
  usbd_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = s_valid && !st.full;
  assign pop = m_ready && !st.empty;
  assign s_ready = !st.full;
  assign m_valid = !st.empty;
  assign m_data = mem[st.rptr];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    next_st.full = (next_st.count == (AW+1)'(DEPTH));
    next_st.empty = (next_st.count == '0);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{wptr: '0, rptr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[st.wptr] <= s_data;
    end
  end
endmodule : usbd_fifo

// ===== usbd_core.sv
// full-speed device port core: link power states and endpoint banks
// Operation
// [R1] six endpoints, one or two banks each, sizes 8, 64 (1-3), 256 (4-5).
// [R2] with two banks the processor fills one while the engine owns the other.
// [R3] isochronous endpoints must be dual banked to hold full bandwidth.
// [R4] suspend and resume are detected in hardware and raise the interrupt.
// [R5] endpoint data enter one 8-bit byte per write.
// [R6] bus-side timing runs from a bit-rate enable derived from the clock; only resume sampling uses it, the suspend and wake timers count clock cycles.
// [R7] the wake input, when allowed by the host, drives a resume request.
// [R8] only this engine drives the data lines of the transceiver.
// [R9] the power manager must clock the port before any access.
// [R10] one interrupt output goes to the interrupt controller.
// [R11] the board pullup line is driven low to connect, high by default; the core has no pullup output.
// [R12] bus-powered boards connect the pullup within 100 ms; the core has no pullup output.
// [R13] loss of bus power is a disconnect and drops the pullup; the core has no bus power input and no pullup output.
// [R14] signals from outside this clock are synchronised before use.
`timescale 1ns/1ps
module usbd_core
  import usbd_pkg::*;
#(
  parameter int SUSP_CYC = `USBD_SUSP_CYC,
  parameter int WAKE_CYC = `USBD_WAKE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dp_in,
  input wire logic dm_in,
  output logic dp_out,
  output logic dm_out,
  output logic dp_oe,
  output logic dm_oe,
  input wire logic ext_resume,
  input wire logic remote_wake_en,
  input wire usbd_pkg::usbd_epmask_t cfg_dual,
  input wire usbd_pkg::usbd_epmask_t cfg_iso,
  input wire logic wr_valid,
  input wire logic [2:0] wr_ep,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  input wire logic commit_valid,
  input wire logic [2:0] commit_ep,
  input wire logic sie_done,
  input wire logic [2:0] sie_ep,
  output usbd_pkg::usbd_epmask_t bank_free,
  output usbd_pkg::usbd_epmask_t sie_ready,
  output logic cfg_error,
  output logic susp_flag,
  output logic resume_flag,
  output logic irq,
  input wire logic irq_ack
);
  import usbd_pkg::*;

  usbd_state_t st;
  usbd_state_t next_st;
  logic f_valid;
  logic f_ready;
  logic [10:0] f_data;
  logic [2:0] f_ep;
  logic commit_take;

  function automatic logic [`USBD_FILL_W-1:0] ep_max(input int ep);
    if (ep == 0) begin
      return `USBD_EP0_MAX; // R1
    end else if (ep < 4) begin
      return `USBD_EP13_MAX; // R1
    end else begin
      return `USBD_EP45_MAX; // R1
    end
  endfunction : ep_max

  // ----------------------------------------------------------------
  // processor byte path
  // ----------------------------------------------------------------
  usbd_fifo #(.WIDTH(11), .DEPTH(`USBD_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .s_valid(wr_valid),
    .s_data({wr_ep, wr_data}),
    .s_ready(wr_ready),
    .m_valid(f_valid),
    .m_data(f_data),
    .m_ready(f_ready)
  );

  assign f_ep = f_data[10:8];
  // byte leaves fifo only into a bank the processor holds
  assign f_ready = (f_ep < 3'(`USBD_EP_NUM))
    && !st.owned[{f_ep, st.cpu_bank[f_ep]}]; // R2 R5
  // commit waits until all queued bytes have landed
  assign commit_take = commit_valid && !f_valid
    && (commit_ep < 3'(`USBD_EP_NUM));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [`USBD_FILL_W-1:0] lvl;
    logic susp_ev;
    logic res_ev;
    next_st = st;
    lvl = '0;
    susp_ev = 1'b0;
    res_ev = 1'b0;
    // three-stage synchronisers, value taken once stages two and three agree
    next_st.sync_dp = {st.sync_dp[1:0], dp_in}; // R14
    next_st.sync_dm = {st.sync_dm[1:0], dm_in}; // R14
    next_st.sync_wk = {st.sync_wk[1:0], ext_resume}; // R14
    if (st.sync_dp[1] == st.sync_dp[2] && st.sync_dm[1] == st.sync_dm[2]) begin
      next_st.line_j = st.sync_dp[2] && !st.sync_dm[2];
      next_st.line_k = !st.sync_dp[2] && st.sync_dm[2];
    end
    if (st.sync_wk[1] == st.sync_wk[2]) begin
      next_st.wk_lvl = st.sync_wk[2];
    end
    // bit-rate enable
    next_st.bit_en = (st.div == `USBD_DIV_W'(`USBD_BIT_DIV - 1)); // R6
    next_st.div = next_st.bit_en ? '0 : st.div + 1'b1; // R6
    // link power states
    case (st.state)
      USBD_ACTIVE: begin
        if (!st.line_j) begin
          next_st.cnt = '0;
        end else if (st.cnt == `USBD_CNT_W'(SUSP_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.state = USBD_SUSPEND; // R4
          susp_ev = 1'b1; // R4
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      USBD_SUSPEND: begin
        if (st.bit_en && st.line_k) begin
          next_st.state = USBD_ACTIVE; // R4
          res_ev = 1'b1; // R4
        end else if (st.wk_lvl && remote_wake_en) begin
          next_st.state = USBD_WAKE; // R7
          next_st.cnt = '0;
        end
      end
      USBD_WAKE: begin
        if (st.cnt == `USBD_CNT_W'(WAKE_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.state = USBD_ACTIVE; // R7
          res_ev = 1'b1; // R7
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      default: begin
        next_st.state = USBD_ACTIVE;
        next_st.cnt = '0;
      end
    endcase
    // lines driven with K only while requesting resume
    next_st.dp_oe = (next_st.state == USBD_WAKE); // R8
    next_st.dm_oe = (next_st.state == USBD_WAKE); // R8
    next_st.dp_out = 1'b0; // R8
    next_st.dm_out = (next_st.state == USBD_WAKE); // R8
    // flags: an event in the acknowledge cycle survives
    next_st.susp_flag = susp_ev || (st.susp_flag && !irq_ack); // R4
    next_st.resume_flag = res_ev || (st.resume_flag && !irq_ack); // R4
    next_st.irq = next_st.susp_flag || next_st.resume_flag; // R10
    // byte into current processor bank, bytes beyond size are dropped
    if (f_valid && f_ready) begin
      lvl = st.fill[f_ep*`USBD_FILL_W +: `USBD_FILL_W];
      if (lvl < ep_max(int'(f_ep))) begin
        next_st.fill[f_ep*`USBD_FILL_W +: `USBD_FILL_W] = lvl + 1'b1; // R1
      end
    end
    // engine releases its bank
    if (sie_done && sie_ep < 3'(`USBD_EP_NUM)) begin
      next_st.owned[{sie_ep, st.sie_bank[sie_ep]}] = 1'b0;
      if (cfg_dual[sie_ep]) begin
        next_st.sie_bank[sie_ep] = !st.sie_bank[sie_ep]; // R2
      end
    end
    // processor hands its bank to the engine
    if (commit_take && !st.owned[{commit_ep, st.cpu_bank[commit_ep]}]) begin
      next_st.owned[{commit_ep, st.cpu_bank[commit_ep]}] = 1'b1;
      next_st.fill[commit_ep*`USBD_FILL_W +: `USBD_FILL_W] = '0;
      if (cfg_dual[commit_ep]) begin
        next_st.cpu_bank[commit_ep] = !st.cpu_bank[commit_ep]; // R2
      end
    end
    for (int e = 0; e < `USBD_EP_NUM; e++) begin
      if (!cfg_dual[e]) begin
        next_st.cpu_bank[e] = 1'b0; // R1
        next_st.sie_bank[e] = 1'b0; // R1
      end
      next_st.bank_free[e] = !next_st.owned[{3'(e), next_st.cpu_bank[e]}];
      next_st.sie_ready[e] = next_st.owned[{3'(e), next_st.sie_bank[e]}];
    end
    next_st.cfg_error = |(cfg_iso & ~cfg_dual); // R3
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= USBD_ACTIVE;
      st.bank_free <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign dp_out = st.dp_out;
  assign dm_out = st.dm_out;
  assign dp_oe = st.dp_oe;
  assign dm_oe = st.dm_oe;
  assign bank_free = st.bank_free;
  assign sie_ready = st.sie_ready;
  assign cfg_error = st.cfg_error;
  assign susp_flag = st.susp_flag;
  assign resume_flag = st.resume_flag;
  assign irq = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  susp_raises_irq_a: assert property ( // R4
    (st.state == USBD_ACTIVE ##1 st.state == USBD_SUSPEND)
      |-> susp_flag && irq)
    else $error("suspend entry without interrupt");
  resume_raises_irq_a: assert property ( // R4
    (st.state == USBD_SUSPEND && st.line_k && st.bit_en) |=> resume_flag && irq)
    else $error("resume seen without interrupt");
  wake_needs_grant_a: assert property ( // R7
    (st.state == USBD_SUSPEND ##1 st.state == USBD_WAKE)
      |-> $past(remote_wake_en))
    else $error("wake signalling without host grant");
  wake_drives_k_a: assert property ( // R8
    (st.state == USBD_WAKE) |-> (dp_oe && dm_oe && !dp_out && dm_out))
    else $error("resume request not driving K");
  lines_released_a: assert property ( // R8
    (st.state != USBD_WAKE) |-> (!dp_oe && !dm_oe))
    else $error("data lines driven outside resume request");
  iso_single_flag_a: assert property ( // R3
    (|(cfg_iso & ~cfg_dual)) |=> cfg_error)
    else $error("single banked isochronous endpoint not flagged");
  dual_commit_flip_a: assert property ( // R2
    (commit_take && cfg_dual[commit_ep] && !sie_done
      && !st.owned[{commit_ep, st.cpu_bank[commit_ep]}])
      |=> st.cpu_bank[$past(commit_ep)] != $past(st.cpu_bank[commit_ep])
        && sie_ready[$past(commit_ep)])
    else $error("dual bank commit did not switch bank");
  single_commit_busy_a: assert property ( // R2
    (commit_take && !cfg_dual[commit_ep] && !sie_done)
      |=> !bank_free[$past(commit_ep)])
    else $error("single bank still free after commit");
  fill_capped_a: assert property ( // R1
    st.fill[0 +: `USBD_FILL_W] <= `USBD_EP0_MAX
      && st.fill[4*`USBD_FILL_W +: `USBD_FILL_W] <= `USBD_EP45_MAX)
    else $error("bank fill beyond endpoint size");
  ack_clears_irq_a: assert property ( // R10
    (irq_ack && st.state == USBD_ACTIVE && !st.line_j) |=> !irq)
    else $error("interrupt not cleared by acknowledge");

  suspend_seen_c: cover property (st.state == USBD_SUSPEND);
  wake_done_c: cover property (st.state == USBD_WAKE ##1 st.state == USBD_ACTIVE);
  both_banks_c: cover property (st.owned[3:2] == 2'b11);
  fifo_full_c: cover property (wr_valid && !wr_ready);
endmodule : usbd_core

// ===== usbd_host_model.sv
// host end of the full-speed bus as seen by the device pads
`timescale 1ns/1ps
module usbd_host_model (
  input wire logic drive_k,
  input wire logic dev_oe,
  input wire logic dev_dp,
  input wire logic dev_dm,
  output logic dp,
  output logic dm
);
  // ----------------------------------------
  // line resolution
  // ----------------------------------------
  always_comb begin
    if (dev_oe) begin
      dp = dev_dp;
      dm = dev_dm;
    end else if (drive_k) begin
      dp = 1'b0;
      dm = 1'b1;
    end else begin
      // idle J: the board pullup is connected and bus power present
      dp = 1'b1;
      dm = 1'b0;
    end
  end
endmodule : usbd_host_model

// ===== usbd_core_tb.sv
// self-checking bench of the device port core
`timescale 1ns/1ps
module usbd_core_tb;
  import usbd_pkg::*;
  logic clock, rst_n, dp_in, dm_in, dp_out, dm_out, dp_oe, dm_oe, drive_k;
  logic ext_resume, remote_wake_en, wr_valid, wr_ready, commit_valid;
  logic sie_done, cfg_error, susp_flag, resume_flag, irq, irq_ack;
  logic [2:0] wr_ep, commit_ep, sie_ep;
  logic [7:0] wr_data;
  usbd_epmask_t cfg_dual, cfg_iso, bank_free, sie_ready;
  int fail_count, comparisons, cycles;

  usbd_core #(.SUSP_CYC(20), .WAKE_CYC(30)) dut_u (
    .clock(clock), .rst_n(rst_n), .dp_in(dp_in), .dm_in(dm_in),
    .dp_out(dp_out), .dm_out(dm_out), .dp_oe(dp_oe), .dm_oe(dm_oe),
    .ext_resume(ext_resume), .remote_wake_en(remote_wake_en),
    .cfg_dual(cfg_dual), .cfg_iso(cfg_iso), .wr_valid(wr_valid),
    .wr_ep(wr_ep), .wr_data(wr_data), .wr_ready(wr_ready),
    .commit_valid(commit_valid), .commit_ep(commit_ep),
    .sie_done(sie_done), .sie_ep(sie_ep), .bank_free(bank_free),
    .sie_ready(sie_ready), .cfg_error(cfg_error), .susp_flag(susp_flag),
    .resume_flag(resume_flag), .irq(irq), .irq_ack(irq_ack));

  usbd_host_model host_u (.drive_k(drive_k), .dev_oe(dp_oe),
    .dev_dp(dp_out), .dev_dm(dm_out), .dp(dp_in), .dm(dm_in));

  // port clock runs from time zero, before any access
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input logic [7:0] got, input logic [7:0] exp, input string s);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : check

  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task put_byte(input logic [2:0] ep, input logic [7:0] d);
    @(negedge clock);
    wr_valid = 1'b1;
    wr_ep = ep;
    wr_data = d;
    // ready is judged off the edge; the byte goes at the next rising edge
    while (wr_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    wr_valid = 1'b0;
  endtask : put_byte

  task commit(input logic [2:0] ep);
    @(negedge clock);
    commit_valid = 1'b1;
    commit_ep = ep;
    @(negedge clock);
    commit_valid = 1'b0;
  endtask : commit

  task done(input logic [2:0] ep);
    @(negedge clock);
    sie_done = 1'b1;
    sie_ep = ep;
    @(negedge clock);
    sie_done = 1'b0;
  endtask : done

  task ack;
    @(negedge clock);
    irq_ack = 1'b1;
    @(negedge clock);
    irq_ack = 1'b0;
  endtask : ack

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_suspend;
    for (int i = 0; i < 60 && susp_flag !== 1'b1; i++) @(negedge clock);
    check(susp_flag, 1, "suspend flag");
    check(irq, 1, "irq on suspend");
    ack();
    check(irq, 0, "irq after ack");
    drive_k = 1'b1;
    for (int i = 0; i < 40 && resume_flag !== 1'b1; i++) @(negedge clock);
    drive_k = 1'b0;
    check(resume_flag, 1, "resume flag");
    check(irq, 1, "irq on resume");
    ack();
    $display("test suspend finished");
  endtask : t_suspend

  task t_wake;
    for (int i = 0; i < 60 && susp_flag !== 1'b1; i++) @(negedge clock);
    ack();
    ext_resume = 1'b1;
    repeat (12) @(negedge clock);
    check(dp_oe, 0, "wake without grant");
    remote_wake_en = 1'b1;
    for (int i = 0; i < 20 && dp_oe !== 1'b1; i++) @(negedge clock);
    check({dp_oe, dp_out, dm_out}, 8'h05, "resume k drive");
    ext_resume = 1'b0;
    for (int i = 0; i < 60 && resume_flag !== 1'b1; i++) @(negedge clock);
    check(resume_flag, 1, "wake resume flag");
    check(dp_oe, 0, "lines released");
    remote_wake_en = 1'b0;
    ack();
    $display("test wake finished");
  endtask : t_wake

  task t_single;
    put_byte(3'h0, 8'h11);
    repeat (4) @(negedge clock);
    commit(3'h0);
    check({bank_free[0], sie_ready[0]}, 8'h01, "ep0 committed");
    for (int i = 0; i < 16; i++) put_byte(3'h0, i[7:0]);
    check(wr_ready, 0, "fifo full");
    done(3'h0);
    check(bank_free[0], 1, "ep0 released");
    for (int i = 0; i < 60 && wr_ready !== 1'b1; i++) @(negedge clock);
    repeat (20) @(negedge clock);
    check(wr_ready, 1, "fifo drained");
    commit(3'h0);
    check(sie_ready[0], 1, "ep0 second packet");
    done(3'h0);
    $display("test single bank finished");
  endtask : t_single

  task t_dual;
    cfg_dual = 6'h02;
    commit(3'h1);
    check({bank_free[1], sie_ready[1]}, 8'h03, "ep1 first");
    commit(3'h1);
    check({bank_free[1], sie_ready[1]}, 8'h01, "ep1 both");
    done(3'h1);
    check({bank_free[1], sie_ready[1]}, 8'h03, "ep1 swap");
    done(3'h1);
    check({bank_free[1], sie_ready[1]}, 8'h02, "ep1 idle");
    $display("test dual bank finished");
  endtask : t_dual

  task t_iso;
    cfg_iso = 6'h10;
    repeat (3) @(negedge clock);
    check(cfg_error, 1, "iso single bank");
    cfg_dual = 6'h12;
    repeat (3) @(negedge clock);
    check(cfg_error, 0, "iso dual bank");
    $display("test iso finished");
  endtask : t_iso

  // bounds a hang at more than ten times the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    {drive_k, ext_resume, remote_wake_en, wr_valid, commit_valid} = 5'h00;
    {sie_done, irq_ack, wr_ep, commit_ep, sie_ep, wr_data} = 19'h00000;
    cfg_dual = 6'h00;
    cfg_iso = 6'h00;
    repeat (5) @(negedge clock);
    check(bank_free, 8'h3f, "reset banks");
    check({wr_ready, irq, dp_oe}, 8'h04, "reset outputs");
    rst_n = 1'b1;
    t_suspend();
    t_wake();
    t_single();
    t_dual();
    t_iso();
    print_verdict();
  end
endmodule : usbd_core_tb
